// ===== rtl/amc_params.svh
// Offsets, field positions, reset values and timing counts of the mode and fault controller
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// ==========================================================================
// Clock and times
`define AMC_CLK_HZ        20000000
`define AMC_TICK_MS       1
`define AMC_TICK_CYC      ((`AMC_CLK_HZ / 1000) * `AMC_TICK_MS)
`define AMC_IDLE_MIN      13
`define AMC_IDLE_MS       (`AMC_IDLE_MIN * 60 * 1000)
`define AMC_RAIL_MS       100
`define AMC_DB_MS         3

// ==========================================================================
// Register byte offsets
`define AMC_OFF_CTRL      8'h00
`define AMC_OFF_STATUS    8'h04
`define AMC_OFF_IRQ_STAT  8'h08
`define AMC_OFF_IRQ_MASK  8'h0c
`define AMC_OFF_IDLE_CNT  8'h10

// ==========================================================================
// Control fields
`define AMC_CTRL_AMP_DIS  0
`define AMC_CTRL_IDLE_RST 1
`define AMC_CTRL_RST      2'h0

// ==========================================================================
// Status fields
`define AMC_ST_OPER       0
`define AMC_ST_RAIL       1
`define AMC_ST_OCP        2
`define AMC_ST_THERM      3
`define AMC_ST_MOV        4
`define AMC_ST_TRIG12     5
`define AMC_ST_TRIG35     6
`define AMC_ST_AUDIO      7
`define AMC_ST_ENLINE     8
`define AMC_ST_AMPRUN     9

// ==========================================================================
// Interrupt events, same layout in status and mask
`define AMC_EV_OPER       0
`define AMC_EV_STBY       1
`define AMC_EV_OCP        2
`define AMC_EV_THERM      3
`define AMC_EV_MOV        4
`define AMC_EV_W          5
`define AMC_MASK_RST      5'h00

`endif

// ===== rtl/amc_pkg.sv
// Types shared by the mode and fault controller
package amc_pkg;

  // Operating modes
  typedef enum logic [1:0] {
    AMC_RAIL_WAIT,
    AMC_STANDBY,
    AMC_OPER
  } amc_mode_e;

  // Inputs arriving from pins and analog detectors
  typedef struct packed {
    logic trig12;
    logic trig35;
    logic audio;
    logic amp_en;
    logic short_det;
    logic zobel_trip;
    logic sat_trip;
    logic ovt_a;
    logic ovt_b;
    logic mains_ov;
  } amc_pins_s;

endpackage

// ===== rtl/amc_sync_filter.sv
// Two-flop synchroniser with per-bit stability filter on a tick enable
`timescale 1ns/10ps
module amc_sync_filter #(
  parameter int unsigned          N       = 10,
  parameter int unsigned          DB      = 3,
  parameter logic        [N-1:0]  RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Slow enable
  input  wire logic         tick,
  // Raw and filtered levels
  input  wire logic [N-1:0] d,
  output logic      [N-1:0] q
);

  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] q_r;
  logic [N-1:0] q_nxt;
  logic [2:0]   cnt_r   [N];
  logic [2:0]   cnt_nxt [N];

  // ========================================================================
  // Filter
  // A level must stand DB ticks before it is passed on; glitches restart it
  always_comb
  begin
    q_nxt = q_r;
    for (int i = 0; i < N; i++)
    begin
      cnt_nxt[i] = cnt_r[i];
      if (s2_r[i] == q_r[i])
        cnt_nxt[i] = 3'h0;
      else if (tick)
      begin
        if (cnt_r[i] >= 3'(DB - 1))
        begin
          q_nxt[i]   = s2_r[i];
          cnt_nxt[i] = 3'h0;
        end
        else
          cnt_nxt[i] = cnt_r[i] + 3'h1;
      end
    end
  end

  // Only the second flop reads the first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      q_r  <= RST_VAL;
      for (int i = 0; i < N; i++)
        cnt_r[i] <= 3'h0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      q_r  <= q_nxt;
      for (int i = 0; i < N; i++)
        cnt_r[i] <= cnt_nxt[i];
    end
  end

  assign q = q_r;

endmodule // amc_sync_filter

// ===== rtl/amc_ctrl.sv
// Mode selection, inactivity timer, fault signalling and AHB-Lite registers
`timescale 1ns/10ps
`include "amc_params.svh"

// Contract
// - Overcurrent monitor high, low on short
// - Zobel or saturation trip also lowers it
// - Overheat: amplifiers off, thermal monitor low
// - Enable line released to internal pull-up
// - Enable line low keeps amplifiers off
// - Overheat or overcurrent drives enable low
// - Either trigger high selects operational mode
// - Triggers low: standby after 13 silent minutes
// - Audio detection selects operational mode
// - Inactivity timer returns to standby
// - Separate operational and standby indicators
// - Standby rail ready 100 ms after power
// - Mains overvoltage holds supply off until standby
module amc_ctrl #(
  parameter int unsigned TICK_CYC = `AMC_TICK_CYC,
  parameter int unsigned IDLE_MS  = `AMC_IDLE_MS
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Pins and detectors
  input  wire amc_pkg::amc_pins_s pins,
  // Fault monitors, active low
  output logic                   ocp_mon_out,
  output logic                   thermal_mon_out,
  // Bidirectional amplifier enable line
  output logic                   amp_en_o,
  output logic                   amp_en_oe_n,
  // Power and indicators
  output logic                   amp_run_out,
  output logic                   on_indicator_out,
  output logic                   standby_indicator_out,
  output logic                   standby_rail_en_out,
  output logic                   main_psu_en_out,
  // Interrupt
  output logic                   irq_out
);
  import amc_pkg::*;

  amc_pins_s          syn;
  logic [14:0]        tick_cnt_r, tick_cnt_nxt;
  logic               tick_r, tick_nxt;
  logic [6:0]         rail_cnt_r, rail_cnt_nxt;
  logic               rail_ok_r, rail_ok_nxt;
  amc_mode_e          mode_r, mode_nxt;
  logic [19:0]        idle_cnt_r, idle_cnt_nxt;
  logic               trig_any_r, trig_any_nxt;
  logic               mov_r, mov_nxt;
  logic               ocp_f_r, ocp_f_nxt;
  logic               therm_f_r, therm_f_nxt;
  logic               amp_run_r, amp_run_nxt;
  logic               en_drive_r, en_drive_nxt;
  logic [1:0]         ctrl_r, ctrl_nxt;
  logic [`AMC_EV_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [`AMC_EV_W-1:0] irq_mask_r, irq_mask_nxt;
  logic               irq_r, irq_nxt;
  logic               dp_wr_r, dp_wr_nxt;
  logic [7:0]         dp_addr_r, dp_addr_nxt;
  logic [31:0]        hrdata_r, hrdata_nxt;
  logic               want_oper;
  logic               trig_fall;
  logic               idle_rst;
  logic [`AMC_EV_W-1:0] ev;
  logic               ap_valid;

  // Register offset decode, shared by read and write paths
  function automatic logic [2:0] reg_dec(input logic [7:0] a);
    case (a)
      `AMC_OFF_CTRL:     reg_dec = 3'h1;
      `AMC_OFF_STATUS:   reg_dec = 3'h2;
      `AMC_OFF_IRQ_STAT: reg_dec = 3'h3;
      `AMC_OFF_IRQ_MASK: reg_dec = 3'h4;
      `AMC_OFF_IDLE_CNT: reg_dec = 3'h5;
      default:           reg_dec = 3'h0;
    endcase
  endfunction

  // ========================================================================
  // Input conditioning
  // Faults pass the same filter; a few ms of latency is far below the
  // analog protection's own reaction time
  amc_sync_filter #(
    .N       (10),
    .DB      (`AMC_DB_MS),
    .RST_VAL (10'h040)
  ) u_filt (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick_r),
    .d     (pins),
    .q     (syn)
  );

  // ========================================================================
  // Millisecond tick and standby rail start-up
  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r + 15'h1;
    tick_nxt     = 1'b0;
    if (tick_cnt_r >= 15'(TICK_CYC - 1))
    begin
      tick_cnt_nxt = 15'h0;
      tick_nxt     = 1'b1;
    end
    rail_cnt_nxt = rail_cnt_r;
    rail_ok_nxt  = rail_ok_r;
    if (tick_r && !rail_ok_r)
    begin
      rail_cnt_nxt = rail_cnt_r + 7'h1;
      if (rail_cnt_r >= 7'(`AMC_RAIL_MS - 1))
        rail_ok_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_r <= 15'h0;
      tick_r     <= 1'b0;
      rail_cnt_r <= 7'h0;
      rail_ok_r  <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      rail_cnt_r <= rail_cnt_nxt;
      rail_ok_r  <= rail_ok_nxt;
    end
  end

  // ========================================================================
  // Mode selection and inactivity timer
  assign want_oper = syn.trig12 | syn.trig35 | syn.audio;
  assign trig_fall = trig_any_r & ~(syn.trig12 | syn.trig35);
  assign idle_rst  = dp_wr_r && reg_dec(dp_addr_r) == 3'h1 && hwdata[`AMC_CTRL_IDLE_RST];

  always_comb
  begin
    mode_nxt     = mode_r;
    trig_any_nxt = syn.trig12 | syn.trig35;
    idle_cnt_nxt = idle_cnt_r;
    // Silence is counted only in operational mode with nothing active
    if (want_oper || trig_fall || idle_rst || mode_r != AMC_OPER)
      idle_cnt_nxt = 20'h0;
    else if (tick_r && idle_cnt_r < 20'(IDLE_MS))
      idle_cnt_nxt = idle_cnt_r + 20'h1;
    case (mode_r)
      AMC_RAIL_WAIT:
        if (rail_ok_r)
          mode_nxt = AMC_STANDBY;
      AMC_STANDBY:
        if (want_oper)
          mode_nxt = AMC_OPER;
      AMC_OPER:
        if (!want_oper && idle_cnt_r >= 20'(IDLE_MS))
          mode_nxt = AMC_STANDBY;
      default:
        mode_nxt = AMC_RAIL_WAIT;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r     <= AMC_RAIL_WAIT;
      trig_any_r <= 1'b0;
      idle_cnt_r <= 20'h0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      trig_any_r <= trig_any_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // ========================================================================
  // Faults, enable line and supply control
  always_comb
  begin
    ocp_f_nxt   = syn.short_det | syn.zobel_trip | syn.sat_trip;
    therm_f_nxt = syn.ovt_a | syn.ovt_b;
    // Overvoltage latch; a new trip wins over the release in standby
    mov_nxt = mov_r;
    if (mode_r == AMC_STANDBY)
      mov_nxt = 1'b0;
    if (syn.mains_ov)
      mov_nxt = 1'b1;
    en_drive_nxt = ocp_f_r | therm_f_r;
    // Line read back low (host or our own pull-down) keeps both channels off
    amp_run_nxt = mode_r == AMC_OPER && syn.amp_en && !therm_f_r && !ocp_f_r
                  && !ctrl_r[`AMC_CTRL_AMP_DIS];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocp_f_r    <= 1'b0;
      therm_f_r  <= 1'b0;
      mov_r      <= 1'b0;
      en_drive_r <= 1'b0;
      amp_run_r  <= 1'b0;
    end
    else
    begin
      ocp_f_r    <= ocp_f_nxt;
      therm_f_r  <= therm_f_nxt;
      mov_r      <= mov_nxt;
      en_drive_r <= en_drive_nxt;
      amp_run_r  <= amp_run_nxt;
    end
  end

  // Output drive from flops
  assign ocp_mon_out           = ~ocp_f_r;
  assign thermal_mon_out       = ~therm_f_r;
  assign amp_en_o              = 1'b0;
  assign amp_en_oe_n           = ~en_drive_r;
  assign amp_run_out           = amp_run_r;
  assign on_indicator_out      = mode_r == AMC_OPER;
  assign standby_indicator_out = mode_r == AMC_STANDBY;
  assign standby_rail_en_out   = rail_ok_r;
  assign main_psu_en_out       = mode_r == AMC_OPER && !mov_r;

  // ========================================================================
  // AHB-Lite slave, control and interrupt registers
  // Zero wait states; reads are fetched in the address phase so hrdata
  // comes from a flop, at the cost of a write-then-read of the same
  // register returning the value from before the write
  assign ap_valid = hsel & htrans[1] & hready;

  assign ev[`AMC_EV_OPER]  = mode_nxt == AMC_OPER && mode_r != AMC_OPER;
  assign ev[`AMC_EV_STBY]  = mode_nxt == AMC_STANDBY && mode_r != AMC_STANDBY;
  assign ev[`AMC_EV_OCP]   = ocp_f_nxt & ~ocp_f_r;
  assign ev[`AMC_EV_THERM] = therm_f_nxt & ~therm_f_r;
  assign ev[`AMC_EV_MOV]   = syn.mains_ov & ~mov_r;

  always_comb
  begin
    dp_wr_nxt    = ap_valid & hwrite;
    dp_addr_nxt  = ap_valid ? haddr[7:0] : dp_addr_r;
    ctrl_nxt     = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    if (dp_wr_r)
    begin
      case (reg_dec(dp_addr_r))
        3'h1:    ctrl_nxt[`AMC_CTRL_AMP_DIS] = hwdata[`AMC_CTRL_AMP_DIS];
        3'h3:    irq_stat_nxt = irq_stat_r & ~hwdata[`AMC_EV_W-1:0];
        3'h4:    irq_mask_nxt = hwdata[`AMC_EV_W-1:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    // Events set after the clear so a coincident event is kept
    irq_stat_nxt = irq_stat_nxt | ev;
    irq_nxt      = |(irq_stat_r & irq_mask_r);
    hrdata_nxt   = hrdata_r;
    if (ap_valid && !hwrite)
    begin
      case (reg_dec(haddr[7:0]))
        3'h1:    hrdata_nxt = {30'h0, ctrl_r};
        3'h2:    hrdata_nxt = {22'h0, amp_run_r, syn.amp_en, syn.audio, syn.trig35,
                               syn.trig12, mov_r, therm_f_r, ocp_f_r, rail_ok_r,
                               mode_r == AMC_OPER};
        3'h3:    hrdata_nxt = {27'h0, irq_stat_r};
        3'h4:    hrdata_nxt = {27'h0, irq_mask_r};
        3'h5:    hrdata_nxt = {12'h0, idle_cnt_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_wr_r    <= 1'b0;
      dp_addr_r  <= 8'h00;
      ctrl_r     <= `AMC_CTRL_RST;
      irq_stat_r <= 5'h00;
      irq_mask_r <= `AMC_MASK_RST;
      irq_r      <= 1'b0;
      hrdata_r   <= 32'h0;
    end
    else
    begin
      dp_wr_r    <= dp_wr_nxt;
      dp_addr_r  <= dp_addr_nxt;
      ctrl_r     <= ctrl_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r      <= irq_nxt;
      hrdata_r   <= hrdata_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign irq_out   = irq_r;

endmodule // amc_ctrl

// ===== verif/amc_ctrl_monitor.sv
// Concurrent checks on the mode and fault controller ports
`timescale 1ns/10ps
module amc_ctrl_monitor #(
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned IDLE_MS  = 20
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // Bus response
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Pins and detectors
  input wire amc_pkg::amc_pins_s pins,
  // Monitors, enable line and mode outputs
  input wire logic               ocp_mon_out,
  input wire logic               thermal_mon_out,
  input wire logic               amp_en_oe_n,
  input wire logic               amp_run_out,
  input wire logic               on_indicator_out,
  input wire logic               standby_indicator_out,
  input wire logic               standby_rail_en_out,
  input wire logic               main_psu_en_out
);
  import amc_pkg::*;
  // ==========================================================================
  // Helper counters
  // Margin covers two sync flops plus a filter that may straddle a tick
  localparam int LIM = 6 * TICK_CYC + 6;
  localparam int IDL = (IDLE_MS - 1) * TICK_CYC;
  localparam int RLO = 99 * TICK_CYC;
  localparam int RHI = 101 * TICK_CYC + 4;
  logic [15:0] oc_r, th_r, ac_r, qt_r, el_r, mv_r, cy_r;

  function automatic logic [15:0] up(input logic [15:0] c, input logic on);
    return on ? c + {15'h0, ~&c} : 16'h0;
  endfunction

  // Raw levels held so far, saturating
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_r <= 16'h0;
      th_r <= 16'h0;
      ac_r <= 16'h0;
      qt_r <= 16'h0;
      el_r <= 16'h0;
      mv_r <= 16'h0;
      cy_r <= 16'h0;
    end
    else
    begin
      oc_r <= up(oc_r, pins.short_det | pins.zobel_trip | pins.sat_trip);
      th_r <= up(th_r, pins.ovt_a | pins.ovt_b);
      ac_r <= up(ac_r, pins.trig12 | pins.trig35 | pins.audio);
      qt_r <= up(qt_r, ~(pins.trig12 | pins.trig35 | pins.audio));
      el_r <= up(el_r, ~pins.amp_en);
      mv_r <= up(mv_r, pins.mains_ov);
      cy_r <= up(cy_r, 1'b1);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_ocp_fault_low: assert property (oc_r >= LIM |-> !ocp_mon_out)
    else $error("overcurrent monitor high during fault");
  a_therm_shut_down: assert property (th_r >= LIM |-> !thermal_mon_out && !amp_run_out)
    else $error("thermal fault not signalled");
  a_en_pull_fault: assert property (!ocp_mon_out || !thermal_mon_out |-> ##[0:2] !amp_en_oe_n)
    else $error("enable line not pulled on fault");
  a_en_line_free: assert property ((ocp_mon_out && thermal_mon_out)[*3] |-> amp_en_oe_n)
    else $error("enable line held without fault");
  a_line_low_off: assert property (el_r >= LIM |-> !amp_run_out)
    else $error("amplifiers run with enable line low");
  a_ind_split: assert property ($past(standby_rail_en_out) |-> on_indicator_out != standby_indicator_out)
    else $error("indicators not exclusive");
  a_wake_oper: assert property (ac_r >= LIM && $past(standby_rail_en_out, 3) |-> on_indicator_out)
    else $error("no operational mode on wake source");
  a_rail_time: assert property ((cy_r < RLO |-> !standby_rail_en_out) and (cy_r > RHI |-> standby_rail_en_out))
    else $error("standby rail timing wrong");
  a_idle_hold: assert property ($fell(on_indicator_out) |-> qt_r >= IDL)
    else $error("standby entered before silence ran out");
  a_mov_psu: assert property (mv_r >= LIM || !on_indicator_out && !$past(on_indicator_out) |-> !main_psu_en_out)
    else $error("main supply enabled wrongly");
  a_mov_latch: assert property (on_indicator_out && $past(on_indicator_out) && !$past(main_psu_en_out) |-> !main_psu_en_out)
    else $error("main supply came back while operational");
  a_ahb_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
endmodule // amc_ctrl_monitor

bind amc_ctrl amc_ctrl_monitor #(.TICK_CYC(TICK_CYC), .IDLE_MS(IDLE_MS)) u_mon (
  .mclk(mclk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
  .ocp_mon_out(ocp_mon_out), .thermal_mon_out(thermal_mon_out),
  .amp_en_oe_n(amp_en_oe_n), .amp_run_out(amp_run_out),
  .on_indicator_out(on_indicator_out), .standby_indicator_out(standby_indicator_out),
  .standby_rail_en_out(standby_rail_en_out), .main_psu_en_out(main_psu_en_out)
);

// ===== verif/amc_host_model.sv
// Host side: amplifier enable line with its pull-up, and the host's standby rail load
`timescale 1ns/10ps
module amc_host_model #(
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Device drive of the line
  input  wire logic amp_en_o,
  input  wire logic amp_en_oe_n,
  // Host pull-down request and wake sources
  input  wire logic host_low,
  input  wire logic host_trig,
  input  wire logic standby_indicator,
  // Resolved line level and heavy load on the standby rail
  output logic      line,
  output logic      rail_load_hi
);
  // Waits in cycles; the load is shed at once, inside both shed limits
  localparam int unsigned TRIG_WAIT  = 470 * TICK_CYC;
  localparam int unsigned AUDIO_WAIT = 410 * TICK_CYC;

  logic        awake;
  logic        trig_d_r;
  logic [15:0] wait_r;
  logic [15:0] wait_nxt;

  // Pull-up wins only when nobody pulls; either party may pull low
  assign line  = (host_low || (!amp_en_oe_n && !amp_en_o)) ? 1'b0 : 1'b1;
  assign awake = host_trig || !standby_indicator;

  // Time awake, saturating; a new trigger restarts the wait
  always_comb
  begin
    wait_nxt = wait_r;
    if (!awake || (host_trig && !trig_d_r))
      wait_nxt = 16'h0;
    else if (wait_r != 16'hffff)
      wait_nxt = wait_r + 16'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r   <= 16'h0;
      trig_d_r <= 1'b0;
    end
    else
    begin
      wait_r   <= wait_nxt;
      trig_d_r <= host_trig;
    end
  end

  // Heavy load only after the wait that fits the wake source
  assign rail_load_hi = awake && wait_r >= (host_trig ? 16'(TRIG_WAIT) : 16'(AUDIO_WAIT));
endmodule // amc_host_model

// ===== verif/amp_mode_and_fault_control_tb.sv
// Self-checking bench for the mode and fault controller
`timescale 1ns/10ps
`include "amc_params.svh"
module amp_mode_and_fault_control_tb;
  import amc_pkg::*;
  localparam int T   = 4;
  localparam int IDL = 20;
  // Pin-order stimulus (enable slot = host pulls low) beside expected outputs
  typedef struct packed
  {
    logic [9:0] in;
    logic [6:0] ex;
  } amc_row_s;
  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0]  pin_r;
  logic        line, ocp, thm, ao, oen, run, on, sb, rail, psu, irq, load;
  logic [6:0]  outv;
  amc_pins_s   pins;
  amc_row_s    rows [13];
  int          fails, checks, n;

  assign pins = amc_pins_s'({pin_r[9:7], line, pin_r[5:0]});
  assign outv = {ocp, thm, on, sb, run, oen, psu};

  amc_ctrl #(.TICK_CYC(T), .IDLE_MS(IDL)) DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins),
    .ocp_mon_out(ocp), .thermal_mon_out(thm), .amp_en_o(ao), .amp_en_oe_n(oen),
    .amp_run_out(run), .on_indicator_out(on), .standby_indicator_out(sb),
    .standby_rail_en_out(rail), .main_psu_en_out(psu), .irq_out(irq)
  );

  amc_host_model #(.TICK_CYC(T)) HM (
    .mclk(mclk), .rst_n(rst_n), .amp_en_o(ao), .amp_en_oe_n(oen), .host_low(pin_r[6]),
    .host_trig(pin_r[9] | pin_r[8]), .standby_indicator(sb), .line(line),
    .rail_load_hi(load)
  );

  // ==========================================================================
  // Tasks
  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task tk(input int k);
    repeat (k * T) @(posedge mclk);
  endtask

  // Bounded wait for the slave's ready at the next edges
  task rdy;
    int c;
    c = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      c++;
      if (c > 50)
      begin
        fails++;
        report_and_stop;
      end
      @(posedge mclk);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    d = hrdata;
  endtask

  // ==========================================================================
  // Clock and sequence
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    rows = '{'{10'h200, 7'h77}, '{10'h100, 7'h77}, '{10'h080, 7'h77}, '{10'h220, 7'h31},
             '{10'h200, 7'h77}, '{10'h210, 7'h31}, '{10'h200, 7'h77}, '{10'h208, 7'h31},
             '{10'h204, 7'h51}, '{10'h200, 7'h77}, '{10'h202, 7'h51}, '{10'h240, 7'h73},
             '{10'h200, 7'h77}};
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    pin_r = 10'h000;
    repeat (3) @(posedge mclk);
    chk({irq, rail, ao, outv}, 10'h062);
    rst_n <= 1'b1;
    tk(`AMC_RAIL_MS - 5);
    chk(rail, 1'b0);
    tk(8);
    chk({rail, sb}, 2'h3);
    // Modes, faults and enable line from the table
    for (int i = 0; i < 13; i++)
    begin
      pin_r <= rows[i].in;
      tk(10);
      chk(outv, rows[i].ex);
    end
    // Interrupt mask, sticky clear, unmapped and status reads
    ahb(1'b0, `AMC_OFF_IRQ_MASK, 32'h0, rd);
    chk(irq, 1'b0);
    chk(rd, 32'h0);
    ahb(1'b1, `AMC_OFF_IRQ_MASK, 32'h1f, rd);
    tk(1);
    chk(irq, 1'b1);
    ahb(1'b1, `AMC_OFF_IRQ_STAT, 32'h1f, rd);
    tk(1);
    chk(irq, 1'b0);
    ahb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, `AMC_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h323);
    ahb(1'b1, `AMC_OFF_CTRL, 32'h1, rd);
    tk(1);
    chk(run, 1'b0);
    ahb(1'b1, `AMC_OFF_CTRL, 32'h0, rd);
    // Mains overvoltage latches the supply off while operational
    pin_r <= 10'h201;
    tk(10);
    chk(psu, 1'b0);
    pin_r <= 10'h200;
    tk(10);
    chk({on, psu}, 2'h2);
    // Audio burst in the silence restarts the idle count
    pin_r <= 10'h000;
    tk(12);
    pin_r <= 10'h080;
    tk(6);
    pin_r <= 10'h000;
    tk(IDL - 4);
    chk(on, 1'b1);
    // Silence count is running; a restart write clears it
    ahb(1'b0, `AMC_OFF_IDLE_CNT, 32'h0, rd);
    chk(32'(rd >= 32'd10), 32'h1);
    ahb(1'b1, `AMC_OFF_CTRL, 32'h2, rd);
    ahb(1'b0, `AMC_OFF_IDLE_CNT, 32'h0, rd);
    chk(rd, 32'h0);
    n = 0;
    while (sb !== 1'b1 && n < 40 * T)
    begin
      @(posedge mclk);
      n++;
    end
    chk(sb, 1'b1);
    chk(load, 1'b0);
    if (sb !== 1'b1)
      report_and_stop;
    pin_r <= 10'h100;
    tk(10);
    chk({on, psu}, 2'h3);
    chk(load, 1'b0);
    // Reset in mid-run with a trigger held: nothing wakes before the rail
    rst_n <= 1'b0;
    tk(1);
    chk({rail, on, sb, oen, psu}, 5'h02);
    rst_n <= 1'b1;
    tk(`AMC_RAIL_MS - 5);
    chk({rail, on}, 2'h0);
    tk(8);
    chk({rail, on, sb}, 3'h6);
    report_and_stop;
  end
endmodule // amp_mode_and_fault_control_tb
